// ===== scs_config_slave.sv
`timescale 1ns/1ps
// Overview of operation
// R1 - serial interface and register access work only while mode pin is high
// R2 - slave address byte is A0 hex with four straps on bits 4 to 1
// R3 - straps have internal pull-downs; an open strap reads zero
// R4 - data line only changes while clock is low, except START and STOP
// R5 - data falling while clock high is START
// R6 - data rising while clock high is STOP
// R7 - idle after bus-free time past STOP, or after maximum clock-high time
// R8 - host write: START, address+0, register address, data, STOP
// R9 - device acks matching address, register address and every written byte
// R10 - host read: write register address, repeated START, address+1
// R11 - after read address ack, device shifts out addressed register, MSB first
// R12 - host ends read with NACK then STOP
// R13 - host writes only permitted de-emphasis codes
// R14 - host keeps output amplitude at least 1000 mV
// R15 - host should soft reset then load recommended settings
// R16 - writing 1 to bit 0 at 0x00 restores all register defaults
// R17 - host writes zero to reserved bits
// R18 - one power-down bit per lane path; set bit powers it down
// R19 - registers return to defaults at power-up and when mode pin low
// R20 - lane power-down bits act only while gate bit at 0x02 is set
// R21 - address mismatch leaves data line released, rest of transfer ignored
module scs_config_slave
  import scs_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // serial bus pins
  input  wire logic       serial_clock_line,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_n,
  // mode and address straps
  input  wire logic       serial_mode_enable_pin,
  input  wire logic [3:0] addr_strap,
  // lane control and bus idle flag
  output logic [7:0]      lane_power_down_bits,
  output logic            bus_idle
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic       scl_s, sda_s, mode_s;
  logic [3:0] strap_s;

  // lines reset to their idle high level: no false clock edge after reset
  scs_sync #(.WIDTH(3), .RST_VAL(3'h7)) u_sync_bus (
    .clk      (clk),
    .resetn   (resetn),
    .pin_in   ({serial_clock_line, sda_in, serial_mode_enable_pin}),
    .pin_sync ({scl_s, sda_s, mode_s})
  );

  // open straps read zero through the internal pull-down
  scs_sync #(.WIDTH(4), .RST_VAL(STRAP_DEFAULT)) u_sync_strap ( // R3
    .clk      (clk),
    .resetn   (resetn),
    .pin_in   (addr_strap),
    .pin_sync (strap_s)
  );

  // ----------------------------------------------------------------
  // line events
  // ----------------------------------------------------------------
  logic scl_d_r, sda_d_r;
  wire  start_ev = mode_s & scl_s & scl_d_r & sda_d_r & ~sda_s;   // R5
  wire  stop_ev  = mode_s & scl_s & scl_d_r & ~sda_d_r & sda_s;   // R6
  wire  scl_rise = scl_s & ~scl_d_r;
  wire  scl_fall = ~scl_s & scl_d_r;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  scs_state_t st_r, st_nxt;
  logic [3:0] cnt_r;
  logic       ack_r;
  logic       rw_r;
  logic       mnack_r;
  logic [7:0] rx_r, tx_r, ptr_r;
  logic       oe_n_r, oe_n_nxt;
  logic [7:0] rst_reg_r, pd_lanes_r, pd_gate_r;
  logic       after_stop_r;
  logic [IDLE_CNT_W-1:0] hi_cnt_r;

  wire byte_done = scl_fall & ~ack_r & (cnt_r == BITS_PER_BYTE);
  wire ack_done  = scl_fall & ack_r;
  wire match     = scs_addr_match(rx_r, strap_s);                 // R2
  wire wr_en     = byte_done & (st_r == ST_WDATA);
  wire soft_rst  = wr_en & (ptr_r == SOFT_RESET_CONTROL_OFS) & rx_r[SOFT_RESET_BIT];
  wire clr_regs  = ~mode_s | soft_rst;                            // R16 R19

  // ----------------------------------------------------------------
  // register read mux
  // ----------------------------------------------------------------
  wire [7:0] rd_data =
    (ptr_r == SOFT_RESET_CONTROL_OFS) ? rst_reg_r  :
    (ptr_r == LANE_POWER_DOWN_OFS)    ? pd_lanes_r :
    (ptr_r == POWER_DOWN_GATE_OFS)    ? pd_gate_r  : UNMAPPED_READ_VAL;

  // ----------------------------------------------------------------
  // next state and data-line drive
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt   = st_r;
    oe_n_nxt = oe_n_r;
    if (!mode_s) begin
      st_nxt   = ST_IDLE;                                         // R1
      oe_n_nxt = 1'b1;
    end else if (start_ev) begin
      st_nxt   = ST_ADDR;
      oe_n_nxt = 1'b1;
    end else if (stop_ev) begin
      st_nxt   = ST_IDLE;
      oe_n_nxt = 1'b1;
    end else if (byte_done) begin
      case (st_r)
        ST_ADDR:  begin
          st_nxt   = match ? ST_ADDR : ST_IGNORE;                 // R21
          oe_n_nxt = ~match;                                      // R9
        end
        ST_REG, ST_WDATA: oe_n_nxt = 1'b0;                        // R9
        default:  oe_n_nxt = 1'b1;
      endcase
    end else if (ack_done) begin
      case (st_r)
        ST_ADDR:  begin
          st_nxt   = rw_r ? ST_RDATA : ST_REG;
          oe_n_nxt = rw_r ? rd_data[7] : 1'b1;                    // R11
        end
        ST_REG:   begin
          st_nxt   = ST_WDATA;
          oe_n_nxt = 1'b1;
        end
        ST_RDATA: begin
          st_nxt   = mnack_r ? ST_IGNORE : ST_RDATA;
          oe_n_nxt = mnack_r ? 1'b1 : rd_data[7];
        end
        default:  oe_n_nxt = 1'b1;
      endcase
    end else if (scl_fall & (st_r == ST_RDATA) & ~ack_r) begin
      oe_n_nxt = tx_r[6];                                         // R4 R11
    end
  end

  // ----------------------------------------------------------------
  // bit engine
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      st_r    <= ST_IDLE;
      oe_n_r  <= 1'b1;
      sda_out <= 1'b0;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
      st_r    <= st_nxt;
      oe_n_r  <= oe_n_nxt;
      sda_out <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r   <= 4'h0;
      ack_r   <= 1'b0;
      rw_r    <= 1'b0;
      mnack_r <= 1'b1;
      rx_r    <= 8'h00;
      tx_r    <= 8'h00;
      ptr_r   <= 8'h00;
    end else if (start_ev | stop_ev | ~mode_s) begin
      cnt_r <= 4'h0;
      ack_r <= 1'b0;
    end else if (byte_done) begin
      cnt_r <= 4'h0;
      ack_r <= 1'b1;
      if (st_r == ST_ADDR)
        rw_r <= rx_r[0];
      if (st_r == ST_REG)
        ptr_r <= rx_r;
    end else if (ack_done) begin
      ack_r <= 1'b0;
      tx_r  <= rd_data;
    end else if (scl_rise & ack_r) begin
      mnack_r <= sda_s;                                           // R12
    end else if (scl_rise) begin
      rx_r  <= {rx_r[6:0], sda_s};
      cnt_r <= cnt_r + 4'h1;
    end else if (scl_fall & (st_r == ST_RDATA)) begin
      tx_r <= {tx_r[6:0], 1'b0};
    end
  end

  assign sda_oe_n = oe_n_r;

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_reg_r  <= SOFT_RESET_CONTROL_RST;
      pd_lanes_r <= LANE_POWER_DOWN_RST;
      pd_gate_r  <= POWER_DOWN_GATE_RST;
    end else if (clr_regs) begin
      rst_reg_r  <= SOFT_RESET_CONTROL_RST;                       // R16 R19
      pd_lanes_r <= LANE_POWER_DOWN_RST;
      pd_gate_r  <= POWER_DOWN_GATE_RST;
    end else if (wr_en) begin
      if (ptr_r == SOFT_RESET_CONTROL_OFS)
        rst_reg_r <= rx_r;
      if (ptr_r == LANE_POWER_DOWN_OFS)
        pd_lanes_r <= rx_r;                                       // R18
      if (ptr_r == POWER_DOWN_GATE_OFS)
        pd_gate_r <= rx_r;
    end
  end

  // lane bits only reach the lanes while the gate bit is set
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)
      lane_power_down_bits <= PD_OFF_VAL;
    else
      lane_power_down_bits <= pd_gate_r[PD_GATE_BIT] ? pd_lanes_r : PD_OFF_VAL; // R20
  end

  // ----------------------------------------------------------------
  // idle detection
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hi_cnt_r     <= '0;
      after_stop_r <= 1'b0;
      bus_idle     <= 1'b0;
    end else begin
      if (stop_ev)
        after_stop_r <= 1'b1;
      else if (start_ev)
        after_stop_r <= 1'b0;
      if (!(scl_s & sda_s))
        hi_cnt_r <= '0;
      else if (hi_cnt_r != T_HIGH_CYC)
        hi_cnt_r <= hi_cnt_r + IDLE_CNT_W'(1);
      bus_idle <= (scl_s & sda_s) &
                  ((after_stop_r & (hi_cnt_r >= T_BUF_CYC)) |
                   (hi_cnt_r >= T_HIGH_CYC));                     // R7
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_addr_byte_in;
    (st_r == ST_ADDR) && byte_done;
  endsequence

  a_match_gets_ack: assert property (@(posedge clk) disable iff (!resetn) // R9
    s_addr_byte_in and (match && mode_s && !start_ev && !stop_ev) |=> !sda_oe_n)
    else $error("matching address not acknowledged");

  a_mismatch_released: assert property (@(posedge clk) disable iff (!resetn) // R21
    (st_r == ST_IGNORE) |-> sda_oe_n)
    else $error("data line driven while ignoring transfer");

  a_mode_low_quiet: assert property (@(posedge clk) disable iff (!resetn) // R1
    !mode_s |=> sda_oe_n && (st_r == ST_IDLE))
    else $error("slave active with mode pin low");

  a_mode_low_defaults: assert property (@(posedge clk) disable iff (!resetn) // R19
    !mode_s |=> (pd_lanes_r == LANE_POWER_DOWN_RST) && (pd_gate_r == POWER_DOWN_GATE_RST))
    else $error("registers not defaulted with mode pin low");

  a_start_to_addr: assert property (@(posedge clk) disable iff (!resetn) // R5
    start_ev |=> (st_r == ST_ADDR) && (cnt_r == 4'h0))
    else $error("start not recognised");

  a_stop_to_idle: assert property (@(posedge clk) disable iff (!resetn) // R6
    stop_ev |=> (st_r == ST_IDLE) && sda_oe_n)
    else $error("stop not recognised");

  a_soft_reset_clears: assert property (@(posedge clk) disable iff (!resetn) // R16
    soft_rst |=> (pd_lanes_r == LANE_POWER_DOWN_RST) ##2
                 (lane_power_down_bits == PD_OFF_VAL))
    else $error("soft reset left registers set");

  a_pd_gate_off: assert property (@(posedge clk) disable iff (!resetn) // R20
    !pd_gate_r[PD_GATE_BIT] |=> (lane_power_down_bits == PD_OFF_VAL))
    else $error("lane power-down active without gate");

  a_sda_change_low: assert property (@(posedge clk) disable iff (!resetn) // R4
    $fell(sda_oe_n) |-> !$past(scl_s))
    else $error("data line pulled low while clock high");

  a_idle_after_high: assert property (@(posedge clk) disable iff (!resetn) // R7
    (hi_cnt_r == T_HIGH_CYC) && scl_s && sda_s |=> bus_idle)
    else $error("bus not idle after maximum clock-high time");

endmodule // scs_config_slave

// ===== scs_pkg.sv
package scs_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] SOFT_RESET_CONTROL_OFS = 8'h00;
  localparam logic [7:0] LANE_POWER_DOWN_OFS    = 8'h01;
  localparam logic [7:0] POWER_DOWN_GATE_OFS    = 8'h02;
  localparam logic [7:0] SOFT_RESET_CONTROL_RST = 8'h00;
  localparam logic [7:0] LANE_POWER_DOWN_RST    = 8'h00;
  localparam logic [7:0] POWER_DOWN_GATE_RST    = 8'h00;
  localparam logic [7:0] UNMAPPED_READ_VAL      = 8'h00;
  localparam logic [7:0] PD_OFF_VAL             = 8'h00;
  localparam int         SOFT_RESET_BIT         = 0;
  localparam int         PD_GATE_BIT            = 0;

  // ----------------------------------------------------------------
  // slave address: base byte, straps replace bits 4:1
  // ----------------------------------------------------------------
  localparam logic [7:0] SLAVE_BASE_BYTE  = 8'ha0;
  localparam int         STRAP_LSB        = 1;
  localparam int         STRAP_MSB        = 4;
  localparam logic [3:0] STRAP_DEFAULT    = 4'h0;
  localparam logic [3:0] BITS_PER_BYTE    = 4'h8;

  // ----------------------------------------------------------------
  // bus timing at the 25 MHz core clock
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 40;
  localparam int T_BUF_NS        = 4700;
  localparam int T_HIGH_MAX_NS   = 50000;
  localparam int IDLE_CNT_W      = 11;
  localparam logic [IDLE_CNT_W-1:0] T_BUF_CYC =
    IDLE_CNT_W'((T_BUF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [IDLE_CNT_W-1:0] T_HIGH_CYC =
    IDLE_CNT_W'(T_HIGH_MAX_NS / CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // transfer phases
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_ADDR   = 3'b001,
    ST_REG    = 3'b010,
    ST_WDATA  = 3'b011,
    ST_RDATA  = 3'b100,
    ST_IGNORE = 3'b101
  } scs_state_t;

  function automatic logic scs_addr_match(input logic [7:0] addr_byte,
                                          input logic [3:0] strap);
    logic [7:0] want;
    want = SLAVE_BASE_BYTE;
    want[STRAP_MSB:STRAP_LSB] = strap;
    return addr_byte[7:1] == want[7:1];
  endfunction

endpackage

// ===== scs_sync.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// two-flop synchroniser for a group of pin levels
// ------------------------------------------------------------------
module scs_sync #(
  parameter int          WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  // levels
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_sync
);

  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_r   <= RST_VAL;
      pin_sync <= RST_VAL;
    end else begin
      meta_r   <= pin_in;
      pin_sync <= meta_r;
    end
  end

endmodule // scs_sync

// ===== scs_host.sv
`timescale 1ns/1ps
module scs_host (
  // clock
  input  wire logic clk,
  // bus pins
  output logic      scl,
  output logic      sda_drv,
  input  wire logic sda_line
);
  logic [7:0] res;
  event       res_ev;

  initial begin
    scl     = 1'b1;
    sda_drv = 1'b1;
    res     = 8'h00;
  end

  // ----------------------------------------------------------------
  // bit level: 8 core clocks per bit, clock low 6, high 2
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  // long low phase leaves room for the slave's 3-clock answer delay
  task automatic bitx(input logic b, output logic r);
    tick(1);
    sda_drv = b;
    tick(5);
    scl = 1'b1;
    tick(1);
    r = sda_line;
    tick(1);
    scl = 1'b0;
  endtask

  // also serves as repeated start from a low clock
  task automatic start();
    tick(1);
    sda_drv = 1'b1;
    tick(3);
    scl = 1'b1;
    tick(4);
    sda_drv = 1'b0;
    tick(4);
    scl = 1'b0;
  endtask

  task automatic stop();
    tick(1);
    sda_drv = 1'b0;
    tick(3);
    scl = 1'b1;
    tick(4);
    sda_drv = 1'b1;
    tick(4);
  endtask

  // ----------------------------------------------------------------
  // byte level: each result is announced through res_ev
  // ----------------------------------------------------------------
  task automatic wbyte(input logic [7:0] d);
    logic r;
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], r);
    end
    bitx(1'b1, a);
    res = {7'h00, a};
    ->res_ev;
  endtask

  task automatic rbyte(input logic nack);
    logic [7:0] q;
    logic       r;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, q[i]);
    end
    bitx(nack, r);
    res = q;
    ->res_ev;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] rg, input logic [7:0] d);
    start();
    wbyte(a);
    wbyte(rg);
    wbyte(d);
    stop();
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] rg);
    start();
    wbyte(a);
    wbyte(rg);
    start();
    wbyte(a | 8'h01);
    rbyte(1'b1);
    stop();
  endtask

  // host acks the first data byte, so the same register comes again
  task automatic rd2_reg(input logic [7:0] a, input logic [7:0] rg);
    start();
    wbyte(a);
    wbyte(rg);
    start();
    wbyte(a | 8'h01);
    rbyte(1'b0);
    rbyte(1'b1);
    stop();
  endtask
endmodule // scs_host

// ===== testbench.sv
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, a, e); end end
module testbench;
  logic       clk;
  logic       resetn;
  logic       mode;
  logic [3:0] strap;
  logic       scl;
  logic       sda_drv;
  wire        sda_line;
  logic       sda_out;
  logic       sda_oe_n;
  logic [7:0] lanes;
  logic       bus_idle;
  logic [7:0] exp_q[$];
  logic [7:0] exp_v;
  logic [7:0] v;
  logic [7:0] adr;
  int         checks;
  int         n_mismatch;
  int         cyc;

  // open drain: either party may pull low, pull-up otherwise
  assign sda_line = sda_drv & (sda_oe_n | sda_out);

  scs_config_slave i_scs_config_slave (
    .clk                    (clk),
    .resetn                 (resetn),
    .serial_clock_line      (scl),
    .sda_in                 (sda_line),
    .sda_out                (sda_out),
    .sda_oe_n               (sda_oe_n),
    .serial_mode_enable_pin (mode),
    .addr_strap             (strap),
    .lane_power_down_bits   (lanes),
    .bus_idle               (bus_idle)
  );

  scs_host i_host (
    .clk      (clk),
    .scl      (scl),
    .sda_drv  (sda_drv),
    .sda_line (sda_line)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk);
  endtask

  // ----------------------------------------------------------------
  // transactions: note expected results, then run the host
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] rg, input logic [7:0] d,
                    input logic nak);
    repeat (3) exp_q.push_back({7'h00, nak});
    i_host.wr_reg(a, rg, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] rg, input logic [7:0] e);
    repeat (3) exp_q.push_back(8'h00);
    exp_q.push_back(e);
    i_host.rd_reg(a, rg);
  endtask

  task automatic rd2(input logic [7:0] a, input logic [7:0] rg, input logic [7:0] e);
    repeat (3) exp_q.push_back(8'h00);
    repeat (2) exp_q.push_back(e);
    i_host.rd2_reg(a, rg);
  endtask

  initial begin
    forever begin
      @(i_host.res_ev);
      exp_v = exp_q.pop_front();
      `CHK(i_host.res, exp_v)
    end
  end

  initial begin
    cyc = 0;
    forever begin
      @(posedge clk);
      cyc++;
      if (cyc == 40000) begin
        n_mismatch++;
        close_out();
      end
    end
  end

  initial begin
    checks     = 0;
    n_mismatch = 0;
    resetn     = 1'b0;
    mode       = 1'b1;
    strap      = 4'h0;
    v          = 8'($urandom(32'hf69e));
    wait_clk(16);
    resetn = 1'b1;
    wait_clk(1300);
    `CHK(bus_idle, 1'b1)
    rd(8'ha0, 8'h01, 8'h00);
    v = 8'($urandom) | 8'h01;
    wr(8'ha0, 8'h01, v, 1'b0);
    wait_clk(60);
    `CHK(bus_idle, 1'b0)
    wait_clk(80);
    `CHK(bus_idle, 1'b1)
    `CHK(lanes, 8'h00)
    wr(8'ha0, 8'h02, 8'h01, 1'b0);
    wait_clk(4);
    `CHK(lanes, v)
    rd(8'ha0, 8'h01, v);
    rd(8'ha0, 8'h02, 8'h01);
    rd2(8'ha0, 8'h01, v);
    rd(8'ha0, 8'h7f, 8'h00);
    // soft reset with reserved bits zero
    wr(8'ha0, 8'h00, 8'h01, 1'b0);
    wait_clk(4);
    `CHK(lanes, 8'h00)
    // unmapped lane settings: acked and discarded
    wr(8'ha0, 8'h18, 8'h88, 1'b0);
    wr(8'ha0, 8'h17, 8'h0f, 1'b0);
    rd(8'ha0, 8'h01, 8'h00);
    for (int i = 0; i < 4; i++) begin
      strap = 4'(4'h1 << i);
      wait_clk(8);
      adr = 8'ha0 | {3'b000, strap, 1'b0};
      v   = 8'($urandom);
      wr(adr, 8'h01, v, 1'b0);
      wr(8'ha0, 8'h01, ~v, 1'b1);
      rd(adr, 8'h01, v);
    end
    strap = 4'h0;
    wait_clk(8);
    wr(8'ha0, 8'h02, 8'h01, 1'b0);
    wr(8'ha0, 8'h01, 8'hff, 1'b0);
    wait_clk(4);
    `CHK(lanes, 8'hff)
    mode = 1'b0;
    wait_clk(10);
    `CHK(lanes, 8'h00)
    wr(8'ha0, 8'h01, 8'h55, 1'b1);
    mode = 1'b1;
    wait_clk(10);
    rd(8'ha0, 8'h01, 8'h00);
    wait_clk(10);
    close_out();
  end
endmodule // testbench
